/* File: stsc_regs.vh */
// Register map, field positions and reset values of the measure timer status block
`ifndef STSC_REGS_VH
`define STSC_REGS_VH

// Word offsets, byte address bits [7:2]
`define STSC_STATUS_IDX 6'h00
`define STSC_CLKSEL_IDX 6'h01
`define STSC_CTRL_IDX 6'h02
`define STSC_INTSTS_IDX 6'h03
`define STSC_INTEN_IDX 6'h04
`define STSC_INTCLR_IDX 6'h05

// Status register fields
`define STSC_PRUP_BIT 7
`define STSC_PWUP_BIT 6
`define STSC_TRST_BIT 5
`define STSC_CNT_BIT 2
`define STSC_WIN_BIT 1
`define STSC_ACQ_BIT 0

// Control register field
`define STSC_GO_BIT 7

// Clock select field width and codes
`define STSC_CSEL_W 3
`define STSC_CSEL_INSTR 3'h0
`define STSC_CSEL_SYS 3'h1
`define STSC_CSEL_FAST 3'h2
`define STSC_CSEL_SLOW 3'h3
`define STSC_CSEL_MED 3'h4
`define STSC_CSEL_MED16 3'h5
`define STSC_CSEL_SEC 3'h6
`define STSC_CSEL_REF 3'h7

// Divide ratio of the medium oscillator tap, as counter terminal value
`define STSC_MED_DIV_LAST 4'hF

// Reset values
`define STSC_RST_REQ 3'h0
`define STSC_RST_CSEL 3'h0
`define STSC_RST_GO 1'b0
`define STSC_RST_INT 3'h0

`endif

/* File: stsc_clk_mux.v */
// Count clock source selector: picks one of eight tick enables, divides medium tap by 16
`timescale 1ns/1ps
`include "stsc_regs.vh"
module stsc_clk_mux (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Source tick enables, one cycle each, synchronous to sys_clk
  input wire instrTick,
  input wire fastOscTick,
  input wire slowOscTick,
  input wire medOscTick,
  input wire secOscTick,
  input wire refClkTick,
  // Selection and result
  input wire [`STSC_CSEL_W-1:0] clkSel,
  output wire countTick
);

  reg [3:0] medDiv_ff;
  reg countTick_ff;
  wire medDivTick;
  wire [7:0] srcTick;

  // Terminal count of the divide by 16 tap
  assign medDivTick = medOscTick && (medDiv_ff == `STSC_MED_DIV_LAST);

  // Sources in code order; the system clock source ticks every cycle
  assign srcTick[`STSC_CSEL_INSTR] = instrTick; // [RL7]
  assign srcTick[`STSC_CSEL_SYS] = 1'b1; // [RL7]
  assign srcTick[`STSC_CSEL_FAST] = fastOscTick; // [RL7]
  assign srcTick[`STSC_CSEL_SLOW] = slowOscTick; // [RL7]
  assign srcTick[`STSC_CSEL_MED] = medOscTick; // [RL7]
  assign srcTick[`STSC_CSEL_MED16] = medDivTick; // [RL7]
  assign srcTick[`STSC_CSEL_SEC] = secOscTick; // [RL7]
  assign srcTick[`STSC_CSEL_REF] = refClkTick; // [RL7]

  // Divider runs free so the tap phase does not depend on the selection
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      medDiv_ff <= 4'h0;
    end else if (medOscTick) begin
      medDiv_ff <= medDiv_ff + 4'h1;
    end
  end

  // Registered pick, so a select change never makes a glitch pulse
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      countTick_ff <= 1'b0;
    end else begin
      countTick_ff <= srcTick[clkSel]; // [RL7]
    end
  end

  assign countTick = countTick_ff;

endmodule // stsc_clk_mux

/* File: stsc_top.v */
// Measure timer status, manual request and count clock select block with AHB-Lite slave
//
// Overview of operation
// RL1: Software sets period update request; hardware clears it when update completes.
// RL2: Software sets pulse width update request; hardware clears it after update.
// RL3: Software sets timer reset request; hardware clears it once reset completes.
// RL4: Read-only counting flag is one while the timer increments.
// RL5: Read-only window flag is one while the measurement window is open.
// RL6: Read-only acquisition flag is one while an acquisition runs.
// RL7: Three-bit select picks the count clock among eight sources.
// RL8: Go bit enables incrementing and acquisition; flags reflect it.
// RL9: Writing zero to request bits does nothing; unused bits read zero.
`timescale 1ns/1ps
`include "stsc_regs.vh"
module stsc_top (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Count datapath status and completion pulses
  input wire countIncrementing,
  input wire windowIsOpen,
  input wire acquisitionRunning,
  input wire periodUpdateDone,
  input wire pulseWidthUpdateDone,
  input wire timerResetDone,
  // Requests and control to the count datapath
  output wire periodUpdateReq,
  output wire pulseWidthUpdateReq,
  output wire timerResetReq,
  output wire acquireGo,
  output wire [`STSC_CSEL_W-1:0] countClockSelect,
  // Count clock source ticks
  input wire instrTick,
  input wire fastOscTick,
  input wire slowOscTick,
  input wire medOscTick,
  input wire secOscTick,
  input wire refClkTick,
  output wire countTick,
  // Interrupt
  output wire irq
);

  // Bus state
  reg wrPend_ff;
  reg [5:0] wrIdx_ff;
  reg rdPend_ff;
  reg [5:0] rdIdx_ff;
  reg [31:0] hrdata_ff;
  reg hreadyout_ff;
  reg hresp_ff;
  // Register contents
  reg [2:0] req_ff;
  reg [`STSC_CSEL_W-1:0] csel_ff;
  reg go_ff;
  reg [2:0] flag_ff;
  reg [2:0] intSts_ff;
  reg [2:0] intEn_ff;
  reg irq_ff;
  // Next values
  reg [2:0] nxt_req;
  reg [`STSC_CSEL_W-1:0] nxt_csel;
  reg nxt_go;
  reg [2:0] nxt_intSts;
  reg [2:0] nxt_intEn;
  reg [31:0] nxt_rdata;
  // Decoded strobes
  wire accept;
  wire wrStrobe;
  wire [2:0] doneEvt;
  wire [2:0] wrBits;

  // Address phase is taken only for a selected NONSEQ or SEQ with bus ready
  assign accept = hsel && htrans[1] && hready;
  assign wrStrobe = wrPend_ff;
  assign wrBits = hwdata[`STSC_PRUP_BIT:`STSC_TRST_BIT];
  assign doneEvt = {periodUpdateDone, pulseWidthUpdateDone, timerResetDone};

  // Address capture; reads take one wait state so data comes from a flop
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_ff <= 1'b0;
      wrIdx_ff <= 6'h00;
      rdPend_ff <= 1'b0;
      rdIdx_ff <= 6'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
    end else begin
      hresp_ff <= 1'b0; // Always OKAY
      wrPend_ff <= accept && hwrite;
      if (accept) begin
        wrIdx_ff <= haddr[7:2];
        rdIdx_ff <= haddr[7:2];
      end
      if (accept && !hwrite) begin
        rdPend_ff <= 1'b1;
        hreadyout_ff <= 1'b0;
      end else if (rdPend_ff) begin
        rdPend_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  // Read mux; unused bits and unmapped words read zero
  always @* begin
    nxt_rdata = 32'h00000000; // [RL9]
    case (rdIdx_ff)
      `STSC_STATUS_IDX: begin
        nxt_rdata[`STSC_PRUP_BIT:`STSC_TRST_BIT] = req_ff;
        nxt_rdata[`STSC_CNT_BIT:`STSC_ACQ_BIT] = flag_ff; // [RL4] [RL5] [RL6]
      end
      `STSC_CLKSEL_IDX: begin
        nxt_rdata[`STSC_CSEL_W-1:0] = csel_ff;
      end
      `STSC_CTRL_IDX: begin
        nxt_rdata[`STSC_GO_BIT] = go_ff;
      end
      `STSC_INTSTS_IDX: begin
        nxt_rdata[`STSC_PRUP_BIT:`STSC_TRST_BIT] = intSts_ff;
      end
      `STSC_INTEN_IDX: begin
        nxt_rdata[`STSC_PRUP_BIT:`STSC_TRST_BIT] = intEn_ff;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // Register updates; a software set wins over a completion in the same cycle
  always @* begin
    nxt_req = req_ff & ~doneEvt; // [RL1] [RL2] [RL3]
    nxt_csel = csel_ff;
    nxt_go = go_ff;
    nxt_intSts = intSts_ff | doneEvt;
    nxt_intEn = intEn_ff;
    if (wrStrobe) begin
      case (wrIdx_ff)
        `STSC_STATUS_IDX: begin
          // Ones set requests, zeros leave them alone
          nxt_req = nxt_req | wrBits; // [RL1] [RL2] [RL3] [RL9]
        end
        `STSC_CLKSEL_IDX: begin
          nxt_csel = hwdata[`STSC_CSEL_W-1:0]; // [RL7]
        end
        `STSC_CTRL_IDX: begin
          nxt_go = hwdata[`STSC_GO_BIT]; // [RL8]
        end
        `STSC_INTEN_IDX: begin
          nxt_intEn = wrBits;
        end
        `STSC_INTCLR_IDX: begin
          // New events in this cycle survive the clear
          nxt_intSts = (intSts_ff & ~wrBits) | doneEvt;
        end
        default: begin
          nxt_req = req_ff & ~doneEvt;
        end
      endcase
    end
  end

  // Register file
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ff <= `STSC_RST_REQ;
      csel_ff <= `STSC_RST_CSEL;
      go_ff <= `STSC_RST_GO;
      intSts_ff <= `STSC_RST_INT;
      intEn_ff <= `STSC_RST_INT;
    end else begin
      req_ff <= nxt_req;
      csel_ff <= nxt_csel;
      go_ff <= nxt_go;
      intSts_ff <= nxt_intSts;
      intEn_ff <= nxt_intEn;
    end
  end

  // Live flags; counting and acquisition forced low while go is off since nothing can count then, window flag is not gated
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_ff <= 3'h0;
    end else begin
      flag_ff[2] <= go_ff && countIncrementing; // [RL4] [RL8]
      flag_ff[1] <= windowIsOpen; // [RL5]
      flag_ff[0] <= go_ff && acquisitionRunning; // [RL6] [RL8]
    end
  end

  // Level interrupt from enabled sticky bits
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_intSts & nxt_intEn);
    end
  end

  // Count clock selection
  stsc_clk_mux u_clk_mux (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .instrTick(instrTick),
    .fastOscTick(fastOscTick),
    .slowOscTick(slowOscTick),
    .medOscTick(medOscTick),
    .secOscTick(secOscTick),
    .refClkTick(refClkTick),
    .clkSel(csel_ff),
    .countTick(countTick)
  );

  // Outputs straight from flops
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign periodUpdateReq = req_ff[2]; // [RL1]
  assign pulseWidthUpdateReq = req_ff[1]; // [RL2]
  assign timerResetReq = req_ff[0]; // [RL3]
  assign acquireGo = go_ff; // [RL8]
  assign countClockSelect = csel_ff;
  assign irq = irq_ff;

endmodule // stsc_top

/* File: stsc_top_asserts.sv */
// Port assertions for the measure timer status block
`timescale 1ns/1ps
module stsc_top_asserts (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Requests and completions
  input wire periodUpdateReq,
  input wire pulseWidthUpdateReq,
  input wire timerResetReq,
  input wire periodUpdateDone,
  input wire pulseWidthUpdateDone,
  input wire timerResetDone,
  // Count clock selection
  input wire [2:0] countClockSelect,
  input wire instrTick,
  input wire fastOscTick,
  input wire countTick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Each request drops the edge after its done pulse
  property p_pr_clr; periodUpdateDone && periodUpdateReq |=> !periodUpdateReq; endproperty
  a_pr_clr: assert property (p_pr_clr) else $error("period req stuck");
  property p_pw_clr; pulseWidthUpdateDone && pulseWidthUpdateReq |=> !pulseWidthUpdateReq;
  endproperty
  a_pw_clr: assert property (p_pw_clr) else $error("width req stuck");
  property p_tr_clr; timerResetDone && timerResetReq |=> !timerResetReq; endproperty
  a_tr_clr: assert property (p_tr_clr) else $error("reset req stuck");
  // A pending request waits for its own completion, not a sibling's
  property p_pr_hold; periodUpdateReq && !periodUpdateDone |=> periodUpdateReq; endproperty
  a_pr_hold: assert property (p_pr_hold) else $error("period req lost");
  property p_pw_hold; pulseWidthUpdateReq && !pulseWidthUpdateDone |=> pulseWidthUpdateReq;
  endproperty
  a_pw_hold: assert property (p_pw_hold) else $error("width req lost");
  // Tick follows the chosen source one cycle later
  property p_sel0; countClockSelect == 3'h0 |=> countTick == $past(instrTick); endproperty
  a_sel0: assert property (p_sel0) else $error("instr tick wrong");
  property p_sel1; countClockSelect == 3'h1 |=> countTick; endproperty
  a_sel1: assert property (p_sel1) else $error("sys tick wrong");
  property p_sel2; countClockSelect == 3'h2 |=> countTick == $past(fastOscTick); endproperty
  a_sel2: assert property (p_sel2) else $error("fast tick wrong");
  // Main scenarios reached
  c_done: cover property (periodUpdateDone && periodUpdateReq);
  c_ref: cover property (countClockSelect == 3'h7);
  c_rst: cover property (timerResetDone && timerResetReq);
endmodule // stsc_top_asserts

bind stsc_top stsc_top_asserts u_stsc_top_asserts (.sys_clk, .rst_b, .periodUpdateReq,
  .pulseWidthUpdateReq, .timerResetReq, .periodUpdateDone, .pulseWidthUpdateDone,
  .timerResetDone, .countClockSelect, .instrTick, .fastOscTick, .countTick);

/* File: tb.sv */
// Self-checking testbench for the measure timer status block
`timescale 1ns/1ps
module tb;
  // Bus, datapath and tick stimulus
  reg sysClk = 0, rstB = 0, hsel = 0, hwrite = 0, rdPhase = 0;
  reg [31:0] haddr = 0, hwdata = 0;
  reg [1:0] htrans = 0;
  reg [2:0] lvl = 0, doneV = 0;
  reg [5:0] ticks = 0;
  wire [31:0] hrdata;
  wire hreadyout, irq, go, ctick;
  wire [2:0] reqs, csel;
  integer errorCnt = 0, totalChecks = 0, seed, i;
  reg [31:0] expQ[$];
  initial forever #4 sysClk = ~sysClk;
  stsc_top u_stsc_top (.sys_clk(sysClk), .rst_b(rstB), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .countIncrementing(lvl[2]),
    .windowIsOpen(lvl[1]), .acquisitionRunning(lvl[0]), .periodUpdateDone(doneV[2]),
    .pulseWidthUpdateDone(doneV[1]), .timerResetDone(doneV[0]), .periodUpdateReq(reqs[2]),
    .pulseWidthUpdateReq(reqs[1]), .timerResetReq(reqs[0]), .acquireGo(go),
    .countClockSelect(csel),
    .instrTick(ticks[0]), .fastOscTick(ticks[1]), .slowOscTick(ticks[2]),
    .medOscTick(ticks[3]), .secOscTick(ticks[4]), .refClkTick(ticks[5]), .countTick(ctick),
    .irq(irq));
  task chk(input string what, input [31:0] exp, got);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read data is taken at the edge where the data phase ends
  always @(posedge sysClk) begin
    if (rdPhase && hreadyout) chk("hrdata", expQ.pop_front(), hrdata);
    if (hreadyout) rdPhase <= hsel && htrans[1] && !hwrite;
  end
  // Random source ticks keep the selector busy
  always @(posedge sysClk) ticks <= 6'($urandom);
  // One single word transfer; waits on the slave, never on a fixed count
  task bus(input w, input [7:0] a, input [31:0] d);
    @(posedge sysClk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {3'h0, d};
    do @(posedge sysClk); while (hreadyout !== 1'b1);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task pulse(input [2:0] v);
    @(posedge sysClk) doneV <= v;
    @(posedge sysClk) doneV <= 3'h0;
  endtask
  task endSim;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short well past the expected run length
  initial begin
    #100000;
    errorCnt++;
    endSim;
  end
  // Main sequence
  initial begin
    seed = $urandom(32'hF1FA);
    repeat (16) @(posedge sysClk);
    rstB <= 1'b1;
    for (i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      wr(8'h04, 32'hFFFFFFF8 | i);
      rd(8'h04, i);
      chk("countClockSelect", i, csel);
      repeat (20) @(posedge sysClk);
      if (i == 1) chk("countTick", 32'h1, ctick);
    end
    $display("clock select done");
    lvl <= 3'h7;
    rd(8'h00, 32'h02);
    wr(8'h08, 32'h80);
    @(posedge sysClk);
    chk("acquireGo", 32'h1, go);
    rd(8'h00, 32'h07);
    lvl <= 3'h5;
    rd(8'h00, 32'h05);
    $display("status flags done");
    wr(8'h10, 32'hE0);
    wr(8'h00, 32'hE0);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'hE5);
    chk("requests", 32'h7, reqs);
    pulse(3'h4);
    rd(8'h00, 32'h65);
    chk("requests", 32'h3, reqs);
    pulse(3'h2);
    rd(8'h00, 32'h25);
    pulse(3'h1);
    rd(8'h00, 32'h05);
    rd(8'h0C, 32'hE0);
    chk("irq", 32'h1, irq);
    wr(8'h14, 32'h80);
    rd(8'h0C, 32'h60);
    wr(8'h10, 32'h0);
    repeat (2) @(posedge sysClk);
    chk("irq", 32'h0, irq);
    wr(8'h14, 32'hE0);
    rd(8'h0C, 32'h0);
    $display("requests done");
    endSim;
  end
endmodule // tb
